//--- include/plqf_pkg.sv
// Package of constants for the per-channel law translator and quadrant forcer.
// Assumes a 16-bit parallel register port with a 14-bit word address.
package plqf_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [13:0] QUAD_REG_BASE  = 14'h0120;
	localparam logic [13:0] CHAN_CTRL_BASE = 14'h2000;
	localparam int          NUM_STREAMS    = 32;
	localparam logic [11:0] QUAD_RESET     = 12'h000;
	localparam logic [4:0]  CHAN_RESET     = 5'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int VD_BIT      = 4;
	localparam int IN_LAW_LSB  = 2;
	localparam int OUT_LAW_LSB = 0;
	localparam int QUAD_W      = 3;
	localparam int QUAD_FIELDS = 4;
	localparam int QUAD_REG_W  = QUAD_W * QUAD_FIELDS;
	localparam int FORCE_EN    = 2;
	localparam int FORCE_MSB   = 1;
	localparam int FORCE_VAL   = 0;

	// ---------------------------------------------------------------
	// Law codes and inversion masks
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		LAW_A     = 2'h0,
		LAW_MU    = 2'h1,
		LAW_A_RAW = 2'h2,
		LAW_MU_RAW = 2'h3
	} plqf_law_t;

	localparam logic [7:0] MASK_A      = 8'h55;
	localparam logic [7:0] MASK_MU     = 8'hFF;
	localparam logic [7:0] MASK_A_RAW  = 8'h00;
	localparam logic [7:0] MASK_MU_RAW = 8'h80;
	localparam logic [7:0] MASK_D_NONE = 8'h00;
	localparam logic [7:0] MASK_D_EVEN = 8'h55;
	localparam logic [7:0] MASK_D_ODD  = 8'hAA;
	localparam logic [7:0] MASK_D_ALL  = 8'hFF;

	// ---------------------------------------------------------------
	// Companding constants
	// ---------------------------------------------------------------
	localparam logic [13:0] MU_BIAS = 14'h0021;
	localparam logic [13:0] MU_CLIP = 14'h1FFF;

	// ---------------------------------------------------------------
	// Stream rates, quadrant sizing and FIFO depth
	// ---------------------------------------------------------------
	localparam int QUAD_SHIFT_BASE = 3;
	localparam int FIFO_DEPTH      = 16;

endpackage

//--- rtl/plqf_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module plqf_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = plqf_pkg::FIFO_DEPTH
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic      [WIDTH-1:0] rd_data
);
	import plqf_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
		$error("plqf_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} plqf_fifo_st_t;

	plqf_fifo_st_t s_q, s_d;
	logic          push, pop;

	// Full and empty come straight from the occupancy count
	assign wr_ready = (s_q.cnt != AW'(0) + (AW+1)'(DEPTH));
	assign rd_valid = (s_q.cnt != '0);
	assign rd_data  = s_q.mem[s_q.rp];
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_valid && rd_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = wr_data;
			s_d.wp          = s_q.wp + AW'(1);
		end
		if (pop)
			s_d.rp = s_q.rp + AW'(1);
		if (push && !pop)
			s_d.cnt = s_q.cnt + (AW+1)'(1);
		else if (pop && !push)
			s_d.cnt = s_q.cnt - (AW+1)'(1);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q.wp  <= '0;
			s_q.rp  <= '0;
			s_q.cnt <= '0;
			s_q.mem <= s_d.mem;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // plqf_fifo

//--- rtl/plqf_core.sv
// Per-channel PCM law translation on the output side and quadrant bit
// forcing on the input side, with a 16-bit register port.
// Assumes stream timing supplies channel numbers and rates per byte.
module plqf_core #(
	parameter int NUM_OUT_CH = 256
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        up_cs,
	input  wire logic        up_rd,
	input  wire logic        up_wr,
	input  wire logic [13:0] up_addr,
	input  wire logic [15:0] up_wdata,
	output logic      [15:0] up_rdata,
	output logic             up_rvalid,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [4:0]  in_stream,
	input  wire logic [7:0]  in_chan,
	input  wire logic [1:0]  in_rate,
	input  wire logic [7:0]  in_data,
	output logic             dm_valid,
	input  wire logic        dm_ready,
	output logic      [4:0]  dm_stream,
	output logic      [7:0]  dm_chan,
	output logic      [7:0]  dm_data,
	input  wire logic        out_req,
	input  wire logic [11:0] out_chan,
	input  wire logic        out_msg,
	input  wire logic [7:0]  out_src,
	output logic             out_valid,
	output logic      [11:0] out_chan_q,
	output logic             out_msg_q,
	output logic      [7:0]  out_byte
);
	import plqf_pkg::*;

	if (NUM_OUT_CH < 1 || NUM_OUT_CH > 4096) begin : g_bad_count
		$error("plqf_core: NUM_OUT_CH must be 1..4096");
	end

	typedef struct packed {
		logic [NUM_OUT_CH-1:0][4:0]               chan_ctrl;
		logic [NUM_STREAMS-1:0][QUAD_REG_W-1:0]   quad;
		logic [15:0]                              rdata;
		logic                                     rvalid;
		logic                                     ovalid;
		logic [11:0]                              ochan;
		logic                                     omsg;
		logic [7:0]                               obyte;
	} plqf_core_st_t;

	plqf_core_st_t s_q, s_d;

	// ---------------------------------------------------------------
	// Companding helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] a_to_mu(input logic [7:0] a);
		logic [12:0] mag;
		logic [13:0] x;
		logic [2:0]  seg;
		logic [3:0]  mant;
		mag = '0;
		x = '0;
		seg = '0;
		if (a[6:4] == 3'h0)
			mag = {8'h00, a[3:0], 1'b1};
		else
			mag = 13'({8'h00, a[3:0], 1'b1} + 13'h0020) << (a[6:4] - 3'h1);
		x = 14'({mag, 1'b0} + MU_BIAS);
		if (x > MU_CLIP)
			x = MU_CLIP;
		for (int i = 5; i <= 12; i++) begin
			if (x[i])
				seg = 3'(i - 5);
		end
		// Shift count widened so segment 7 does not wrap to a zero shift
		mant = 4'(x >> (4'(seg) + 4'h1));
		// True A sign 1 means positive; true mu sign 1 means negative
		return {~a[7], seg, mant};
	endfunction

	function automatic logic [7:0] mu_to_a(input logic [7:0] m);
		logic [13:0] mag;
		logic [11:0] l;
		logic [2:0]  seg;
		logic [3:0]  mant;
		mag = 14'((({9'h000, m[3:0], 1'b0} + MU_BIAS) << m[6:4]) - MU_BIAS);
		l = mag[12:1];
		seg = '0;
		for (int i = 5; i <= 11; i++) begin
			if (l[i])
				seg = 3'(i - 4);
		end
		if (seg == 3'h0)
			mant = l[4:1];
		else
			mant = 4'(l >> seg);
		return {~m[7], seg, mant};
	endfunction

	function automatic logic [7:0] voice_mask(input logic [1:0] law);
		case (law)
			LAW_A:      voice_mask = MASK_A;
			LAW_MU:     voice_mask = MASK_MU;
			LAW_A_RAW:  voice_mask = MASK_A_RAW;
			default:    voice_mask = MASK_MU_RAW;
		endcase
	endfunction

	function automatic logic [7:0] data_mask(input logic [1:0] law);
		case (law)
			2'h0:    data_mask = MASK_D_NONE;
			2'h1:    data_mask = MASK_D_EVEN;
			2'h2:    data_mask = MASK_D_ODD;
			default: data_mask = MASK_D_ALL;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Output-side translation
	// ---------------------------------------------------------------
	logic [4:0] entry;
	logic       is_data;
	logic [1:0] law_in, law_out;
	logic [7:0] true_code, conv_code, xlat_byte;

	// Compared at 13 bits so a full 4096-entry table is not cut to zero
	assign entry   = ({1'b0, out_chan} < 13'(NUM_OUT_CH)) ? s_q.chan_ctrl[out_chan] : CHAN_RESET;
	assign is_data = entry[VD_BIT];
	assign law_in  = entry[IN_LAW_LSB +: 2];
	assign law_out = entry[OUT_LAW_LSB +: 2];

	always_comb begin
		true_code = out_src;
		conv_code = out_src;
		xlat_byte = out_src;
		if (law_in == law_out) begin
			xlat_byte = out_src;
		end else if (is_data) begin
			// One select governs both sides, so data stays data
			xlat_byte = out_src ^ data_mask(law_in) ^ data_mask(law_out);
		end else begin
			true_code = out_src ^ voice_mask(law_in);
			if (law_in[0] == law_out[0])
				conv_code = true_code;
			else if (law_in[0])
				conv_code = mu_to_a(true_code);
			else
				conv_code = a_to_mu(true_code);
			xlat_byte = conv_code ^ voice_mask(law_out);
		end
	end

	// ---------------------------------------------------------------
	// Input-side quadrant forcing
	// ---------------------------------------------------------------
	logic [11:0] qreg;
	logic [1:0]  quad_idx;
	logic [2:0]  fcode;
	logic [7:0]  forced;
	logic [20:0] fifo_head;

	assign qreg     = s_q.quad[in_stream];
	assign quad_idx = 2'(in_chan >> (QUAD_SHIFT_BASE + int'(in_rate)));
	assign fcode    = qreg[quad_idx*QUAD_W +: QUAD_W];

	// Host keeps this off on streams with the error-rate receiver running
	always_comb begin
		forced = in_data;
		if (fcode[FORCE_EN]) begin
			if (fcode[FORCE_MSB])
				forced[7] = fcode[FORCE_VAL];
			else
				forced[0] = fcode[FORCE_VAL];
		end
	end

	// Forced bytes queue toward data memory; a stalled store stalls input
	plqf_fifo #(
		.WIDTH (21),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.wr_valid (in_valid),
		.wr_ready (in_ready),
		.wr_data  ({in_stream, in_chan, forced}),
		.rd_valid (dm_valid),
		.rd_ready (dm_ready),
		.rd_data  (fifo_head)
	);

	assign {dm_stream, dm_chan, dm_data} = fifo_head;

	// ---------------------------------------------------------------
	// Register port and state update
	// ---------------------------------------------------------------
	logic        hit_quad, hit_chan;
	logic [11:0] chan_ofs;
	logic [4:0]  quad_ofs;

	assign hit_quad = (up_addr >= QUAD_REG_BASE) &&
	                  (up_addr < QUAD_REG_BASE + 14'(NUM_STREAMS));
	assign hit_chan = (up_addr >= CHAN_CTRL_BASE) &&
	                  (up_addr < CHAN_CTRL_BASE + 14'(NUM_OUT_CH));
	assign quad_ofs = 5'(up_addr - QUAD_REG_BASE);
	assign chan_ofs = 12'(up_addr - CHAN_CTRL_BASE);

	always_comb begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;
		if (up_cs && up_wr) begin
			if (hit_quad)
				s_d.quad[quad_ofs] = up_wdata[QUAD_REG_W-1:0];
			if (hit_chan)
				s_d.chan_ctrl[chan_ofs] = up_wdata[4:0];
		end
		if (up_cs && up_rd) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = 16'h0000;
			if (hit_quad)
				s_d.rdata = {4'h0, s_q.quad[quad_ofs]};
			if (hit_chan)
				s_d.rdata = {11'h000, s_q.chan_ctrl[chan_ofs]};
		end
		// Switched and message-sourced bytes share the same path
		s_d.ovalid = out_req;
		if (out_req) begin
			s_d.ochan = out_chan;
			s_d.omsg  = out_msg;
			s_d.obyte = xlat_byte;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q.chan_ctrl <= {NUM_OUT_CH{CHAN_RESET}};
			s_q.quad      <= {NUM_STREAMS{QUAD_RESET}};
			s_q.rdata     <= 16'h0000;
			s_q.rvalid    <= 1'b0;
			s_q.ovalid    <= 1'b0;
			s_q.ochan     <= 12'h000;
			s_q.omsg      <= 1'b0;
			s_q.obyte     <= 8'h00;
		end else begin
			s_q <= s_d;
		end
	end

	assign up_rdata   = s_q.rdata;
	assign up_rvalid  = s_q.rvalid;
	assign out_valid  = s_q.ovalid;
	assign out_chan_q = s_q.ochan;
	assign out_msg_q  = s_q.omsg;
	assign out_byte   = s_q.obyte;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_read_upper_zero: assert property (@(posedge ref_clk) disable iff (srst)
		up_cs && up_rd && hit_chan |=> up_rvalid && up_rdata[15:5] == 11'h000)
		else $error("entry read upper bits not zero");
	a_same_law_pass: assert property (@(posedge ref_clk) disable iff (srst)
		out_req && law_in == law_out |=> out_valid && out_byte == $past(out_src))
		else $error("equal laws altered the byte");
	a_data_none_even: assert property (@(posedge ref_clk) disable iff (srst)
		out_req && is_data && law_in == 2'h0 && law_out == 2'h1
		|=> out_byte == ($past(out_src) ^ 8'h55))
		else $error("even bit inversion wrong");
	a_data_none_odd: assert property (@(posedge ref_clk) disable iff (srst)
		out_req && is_data && law_in == 2'h0 && law_out == 2'h2
		|=> out_byte == ($past(out_src) ^ 8'hAA))
		else $error("odd bit inversion wrong");
	a_data_all_inv: assert property (@(posedge ref_clk) disable iff (srst)
		out_req && is_data && law_in == 2'h3 && law_out == 2'h0
		|=> out_byte == ~$past(out_src))
		else $error("all bit inversion wrong");
	a_araw_to_a: assert property (@(posedge ref_clk) disable iff (srst)
		out_req && !is_data && law_in == 2'h2 && law_out == 2'h0
		|=> out_byte == ($past(out_src) ^ 8'h55))
		else $error("raw A-law to A-law wrong");
	a_muraw_to_mu: assert property (@(posedge ref_clk) disable iff (srst)
		out_req && !is_data && law_in == 2'h3 && law_out == 2'h1
		|=> out_byte == ($past(out_src) ^ 8'h7F))
		else $error("raw mu-law to mu-law wrong");
	a_quad_lsb_force: assert property (@(posedge ref_clk) disable iff (srst)
		in_valid && fcode == 3'h5 |-> forced[0] && forced[7:1] == in_data[7:1])
		else $error("LSB force to one wrong");
	a_quad_msb_force: assert property (@(posedge ref_clk) disable iff (srst)
		in_valid && fcode == 3'h6 |-> !forced[7] && forced[6:0] == in_data[6:0])
		else $error("MSB force to zero wrong");
	a_quad_normal: assert property (@(posedge ref_clk) disable iff (srst)
		in_valid && !fcode[2] |-> forced == in_data)
		else $error("normal quadrant altered data");

endmodule // plqf_core

//--- bench/plqf_dm_sink.sv
// Data-memory sink model standing behind the quadrant forcing FIFO.
// Assumes one clock, synchronous reset and a valid/ready handshake.
module plqf_dm_sink (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       stall,
	input  wire logic       slow,
	input  wire logic       dm_valid,
	output logic            dm_ready,
	input  wire logic [4:0] dm_stream,
	input  wire logic [7:0] dm_chan,
	input  wire logic [7:0] dm_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        tog_q;
	logic [20:0] got_q[$];
	// Slow mode takes every other cycle, so the FIFO sees back-pressure
	assign dm_ready = !stall && (!slow || tog_q);
	always @(posedge ref_clk) begin
		if (srst) begin
			tog_q <= 1'b0;
		end else begin
			tog_q <= !tog_q;
			if (dm_valid && dm_ready) begin
				got_q.push_back({dm_stream, dm_chan, dm_data});
			end
		end
	end
endmodule // plqf_dm_sink

//--- bench/testbench.sv
// Self-checking bench for the law translator and quadrant forcer.
// Assumes the design package is compiled first and the sink model drains dm_*.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import plqf_pkg::*;
	localparam int         NOC   = 16;
	localparam logic [7:0] DM[4] = '{MASK_D_NONE, MASK_D_EVEN, MASK_D_ODD, MASK_D_ALL};
	localparam logic [7:0] VM[4] = '{MASK_A, MASK_MU, MASK_A_RAW, MASK_MU_RAW};
	logic        ref_clk, srst, up_cs, up_rd, up_wr, up_rvalid, stall, slow;
	logic        in_valid, in_ready, dm_valid, dm_ready, out_req, out_msg, out_valid, out_msg_q;
	logic [13:0] up_addr;
	logic [15:0] up_wdata, up_rdata;
	logic [4:0]  in_stream, dm_stream;
	logic [7:0]  in_chan, in_data, dm_chan, dm_data, out_src, out_byte, src;
	logic [1:0]  in_rate;
	logic [11:0] out_chan, out_chan_q;
	logic [2:0]  code;
	logic [7:0]  d;
	logic [20:0] exp_q[$];
	int          error_cnt, total_checks, i, j, s, r, q, e, n, cnt;

	plqf_core #(.NUM_OUT_CH(NOC)) dut_u (.ref_clk(ref_clk), .srst(srst), .up_cs(up_cs),
		.up_rd(up_rd), .up_wr(up_wr), .up_addr(up_addr), .up_wdata(up_wdata),
		.up_rdata(up_rdata), .up_rvalid(up_rvalid), .in_valid(in_valid), .in_ready(in_ready),
		.in_stream(in_stream), .in_chan(in_chan), .in_rate(in_rate), .in_data(in_data),
		.dm_valid(dm_valid), .dm_ready(dm_ready), .dm_stream(dm_stream), .dm_chan(dm_chan),
		.dm_data(dm_data), .out_req(out_req), .out_chan(out_chan), .out_msg(out_msg),
		.out_src(out_src), .out_valid(out_valid), .out_chan_q(out_chan_q),
		.out_msg_q(out_msg_q), .out_byte(out_byte));
	plqf_dm_sink sink_u (.ref_clk(ref_clk), .srst(srst), .stall(stall), .slow(slow),
		.dm_valid(dm_valid), .dm_ready(dm_ready), .dm_stream(dm_stream), .dm_chan(dm_chan),
		.dm_data(dm_data));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task reg_wr(input logic [13:0] a, input logic [15:0] v);
		@(negedge ref_clk);
		up_cs = 1; up_wr = 1; up_addr = a; up_wdata = v;
		@(negedge ref_clk);
		up_cs = 0; up_wr = 0;
	endtask
	task reg_rd(input logic [13:0] a, input logic [15:0] v);
		@(negedge ref_clk);
		up_cs = 1; up_rd = 1; up_addr = a;
		@(negedge ref_clk);
		up_cs = 0; up_rd = 0;
		chk({15'h0, up_rvalid}, 16'h0001);
		chk(up_rdata, v);
	endtask
	task xlate(input logic [11:0] c, input logic m, input logic [7:0] sv, input logic [7:0] x);
		@(negedge ref_clk);
		chk({15'h0, out_valid}, 16'h0000);
		out_req = 1; out_chan = c; out_msg = m; out_src = sv;
		@(negedge ref_clk);
		out_req = 0;
		chk({15'h0, out_valid}, 16'h0001);
		chk({8'h0, out_byte}, {8'h0, x});
		chk({4'h0, out_chan_q}, {4'h0, c});
		chk({15'h0, out_msg_q}, {15'h0, m});
	endtask
	task in_put(input logic [4:0] st, input logic [7:0] c, input logic [1:0] rt,
		input logic [7:0] v);
		int k;
		@(negedge ref_clk);
		for (k = 0; k < 300 && in_ready !== 1'b1; k++) @(negedge ref_clk);
		// A FIFO that never frees a slot counts as a mismatch
		chk({15'h0, in_ready}, 16'h0001);
		in_valid = 1; in_stream = st; in_chan = c; in_rate = rt; in_data = v;
		@(posedge ref_clk);
	endtask

	// ---------------------------------------------------------------
	// Clock, watchdog and tests
	// ---------------------------------------------------------------
	initial begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		give_verdict();
	end
	initial begin
		{up_cs, up_rd, up_wr, in_valid, out_req, out_msg, slow} = '0;
		{up_addr, up_wdata, in_stream, in_chan, in_rate, in_data, out_chan, out_src} = '0;
		srst = 1; stall = 1; error_cnt = 0; total_checks = 0; cnt = 0;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		srst = 0;
		reg_rd(QUAD_REG_BASE + 14'd5, 16'h0000);
		reg_rd(CHAN_CTRL_BASE + 14'd7, 16'h0000);
		reg_wr(QUAD_REG_BASE + 14'd31, 16'hFFFF);
		reg_rd(QUAD_REG_BASE + 14'd31, 16'h0FFF);
		reg_wr(CHAN_CTRL_BASE + 14'd3, 16'hFFFF);
		reg_rd(CHAN_CTRL_BASE + 14'd3, 16'h001F);
		reg_wr(14'h0000, 16'h1234);
		reg_rd(14'h0000, 16'h0000);
		// Every data code pair, each same-family one followed by its voice pair
		for (i = 0; i < 4; i++) begin
			for (j = 0; j < 4; j++) begin
				src = {i[1:0], j[1:0], 4'h6};
				reg_wr(CHAN_CTRL_BASE + 14'(NOC - 1), {11'h0, 1'b1, i[1:0], j[1:0]});
				xlate(12'(NOC - 1), j[0], src, src ^ DM[i] ^ DM[j]);
				if (i[0] == j[0]) begin
					reg_wr(CHAN_CTRL_BASE + 14'(NOC - 1), {11'h0, 1'b0, i[1:0], j[1:0]});
					xlate(12'(NOC - 1), i[1], src, src ^ VM[i] ^ VM[j]);
				end
			end
		end
		// Out-of-range channel must not borrow entry 0
		reg_wr(CHAN_CTRL_BASE, 16'h0013);
		xlate(12'd20, 1'b0, 8'h5A, 8'h5A);
		// Mixed families go through companding, mid range and full scale, both ways
		reg_wr(CHAN_CTRL_BASE + 14'(NOC - 1), 16'h0001);
		xlate(12'(NOC - 1), 1'b0, 8'hE5, 8'hCD);
		xlate(12'(NOC - 1), 1'b1, 8'hAA, 8'h80);
		reg_wr(CHAN_CTRL_BASE + 14'(NOC - 1), 16'h0004);
		xlate(12'(NOC - 1), 1'b0, 8'hCD, 8'hE5);
		xlate(12'(NOC - 1), 1'b1, 8'h80, 8'hAA);
		reg_wr(QUAD_REG_BASE, 16'h0FAC);
		reg_wr(QUAD_REG_BASE + 14'd1, 16'h06DB);
		// Sink stalls until the FIFO refuses, then drains slowly
		for (s = 0; s < 2; s++) begin
			for (r = 0; r < 4; r++) begin
				for (q = 0; q < 4; q++) begin
					for (e = 0; e < 2; e++) begin
						if (cnt == 16) begin
							@(negedge ref_clk);
							chk({15'h0, in_ready}, 16'h0000);
							stall = 0; slow = 1;
						end
						code = s[0] ? 3'b011 : 3'(4 + q);
						n = 8 << r;
						d = code[0] ? 8'h7E : 8'h81;
						exp_q.push_back({s[4:0], 8'(q * n + e * (n - 1)), !code[2] ? d :
							code[1] ? {code[0], d[6:0]} : {d[7:1], code[0]}});
						in_put(s[4:0], 8'(q * n + e * (n - 1)), r[1:0], d);
						cnt++;
					end
				end
			end
		end
		@(negedge ref_clk);
		in_valid = 0;
		for (i = 0; i < 400 && sink_u.got_q.size() < 64; i++) @(negedge ref_clk);
		chk(16'(sink_u.got_q.size()), 16'd64);
		for (i = 0; i < 64 && i < sink_u.got_q.size(); i++) begin
			chk(16'(sink_u.got_q[i][20:8]), 16'(exp_q[i][20:8]));
			chk({8'h0, sink_u.got_q[i][7:0]}, {8'h0, exp_q[i][7:0]});
		end
		give_verdict();
	end
endmodule // testbench
